// ### dmr_defs.svh
// Register offsets, field positions and reset values of the diagnostic readback bank
`ifndef DMR_DEFS_SVH
`define DMR_DEFS_SVH
`define DMR_OFS_CFG 8'h59
`define DMR_OFS_BAT_HI 8'h5a
`define DMR_OFS_BAT_LO 8'h5b
`define DMR_OFS_BIAS_HI 8'h5c
`define DMR_OFS_BIAS_LO 8'h5d
`define DMR_OFS_INPUT_ONE_POSITIVE_HI 8'h5e
`define DMR_OFS_INPUT_ONE_POSITIVE_LO 8'h5f
`define DMR_CFG_FREEZE_BIT 0
`define DMR_CFG_UPPER_MSB 7
`define DMR_CFG_UPPER_LSB 4
`define DMR_CFG_RST 8'h00
`define DMR_RESULT_RST 12'h000
`define DMR_TAG_BAT 4'h0
`define DMR_TAG_BIAS 4'h1
`define DMR_TAG_INPUT_ONE_POSITIVE 4'h2
`endif

// ### dmr_pkg.sv
// Types shared by the diagnostic readback bank
package dmr_pkg;
    typedef logic [11:0] dmr_result_t;
    typedef logic [3:0] dmr_tag_t;
    typedef enum logic [1:0] {DMR_SRC_BAT, DMR_SRC_BIAS, DMR_SRC_INPUT_ONE_POSITIVE, DMR_SRC_NONE} dmr_src_t;
endpackage : dmr_pkg

// ### dmr_result_slot.sv
// One held result register of a monitored source
`timescale 1ns/1ps
`include "dmr_defs.svh"
module dmr_result_slot
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Update control
    input wire logic load_i,
    input wire logic freeze_i,
    input wire dmr_pkg::dmr_result_t sample_i,
    // Held value
    output dmr_pkg::dmr_result_t value_o
);
    dmr_pkg::dmr_result_t value_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            value_reg <= `DMR_RESULT_RST;
        else if (load_i && !freeze_i)
            value_reg <= sample_i;
    end

    assign value_o = value_reg;
endmodule : dmr_result_slot

// ### dmr_readback.sv
// Wishbone register bank for diagnostic monitor results with update freeze
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "dmr_defs.svh"

// Notes on behaviour
// - Freeze clear: each result register reloads on each new conversion of its own source.
// - Freeze set: result registers hold their values for consistent readback.
// - Freeze control is bit 0 of config at 0x59, reset zero.
// - High register bits 7..0 show result bits 11..4, reset zero.
// - Low register bits 7..4 show result bits 3..0, reset zero.
// - Battery pair at 0x5a/0x5b, tag 0000b.
// - Bias pair at 0x5c/0x5d, tag 0001b.
// - Input one positive pair at 0x5e/0x5f, tag 0010b.
module dmr_readback
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_sel_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Converter results, same clock
    input wire logic conv_valid_i,
    input wire logic [1:0] conv_src_i,
    input wire dmr_pkg::dmr_result_t conv_data_i,
    // Status
    output logic freeze_monitor_update_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] cfg_reg;
    logic ack_reg;
    logic err_reg;
    logic [7:0] rdata_reg;
    logic req;
    logic hit;
    logic [2:0] load;
    dmr_pkg::dmr_result_t bat_val;
    dmr_pkg::dmr_result_t bias_val;
    dmr_pkg::dmr_result_t input_one_positive_val;
    logic [7:0] rdata_next;
    logic freeze;

    assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    assign freeze = cfg_reg[`DMR_CFG_FREEZE_BIT];
    assign hit = (wb_adr_i >= `DMR_OFS_CFG) && (wb_adr_i <= `DMR_OFS_INPUT_ONE_POSITIVE_LO);

    ////////////////////////////////////////////////////////////////////////
    // Configuration: upper nibble stored, bits 3..1 read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_reg <= `DMR_CFG_RST;
        else if (req && wb_we_i && wb_sel_i && wb_adr_i == `DMR_OFS_CFG)
        begin
            cfg_reg[`DMR_CFG_UPPER_MSB:`DMR_CFG_UPPER_LSB] <= wb_dat_i[7:4];
            cfg_reg[3:1] <= 3'h0;
            cfg_reg[`DMR_CFG_FREEZE_BIT] <= wb_dat_i[`DMR_CFG_FREEZE_BIT];
        end
    end

    assign freeze_monitor_update_o = freeze;

    ////////////////////////////////////////////////////////////////////////
    // Result slots; a sample arriving while frozen is dropped, not queued
    always_comb
    begin
        load = 3'h0;
        if (conv_valid_i)
        begin
            case (dmr_pkg::dmr_src_t'(conv_src_i))
                dmr_pkg::DMR_SRC_BAT: load[0] = 1'b1;
                dmr_pkg::DMR_SRC_BIAS: load[1] = 1'b1;
                dmr_pkg::DMR_SRC_INPUT_ONE_POSITIVE: load[2] = 1'b1;
                default: load = 3'h0;
            endcase
        end
    end

    dmr_result_slot u_bat
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(load[0]),
        .freeze_i(freeze),
        .sample_i(conv_data_i),
        .value_o(bat_val)
    );

    dmr_result_slot u_bias
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(load[1]),
        .freeze_i(freeze),
        .sample_i(conv_data_i),
        .value_o(bias_val)
    );

    dmr_result_slot u_input_one_positive
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(load[2]),
        .freeze_i(freeze),
        .sample_i(conv_data_i),
        .value_o(input_one_positive_val)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb
    begin
        rdata_next = 8'h00;
        case (wb_adr_i)
            `DMR_OFS_CFG: rdata_next = cfg_reg;
            `DMR_OFS_BAT_HI: rdata_next = bat_val[11:4];
            `DMR_OFS_BAT_LO: rdata_next = {bat_val[3:0], `DMR_TAG_BAT};
            `DMR_OFS_BIAS_HI: rdata_next = bias_val[11:4];
            `DMR_OFS_BIAS_LO: rdata_next = {bias_val[3:0], `DMR_TAG_BIAS};
            `DMR_OFS_INPUT_ONE_POSITIVE_HI: rdata_next = input_one_positive_val[11:4];
            `DMR_OFS_INPUT_ONE_POSITIVE_LO: rdata_next = {input_one_positive_val[3:0], `DMR_TAG_INPUT_ONE_POSITIVE};
            default: rdata_next = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer: one cycle after the request, held for one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= req && hit;
            err_reg <= req && !hit;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_reg <= 8'h00;
        else if (req && !wb_we_i)
            rdata_reg <= rdata_next;
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_bat_sample;
        conv_valid_i && conv_src_i == 2'h0 && !freeze;
    endsequence

    property p_refresh;
        @(posedge clk_i) disable iff (rst_i)
        s_bat_sample |=> bat_val == $past(conv_data_i);
    endproperty
    a_refresh: assert property (p_refresh) else $error("result not refreshed");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        freeze |=> $stable(bat_val) && $stable(bias_val) && $stable(input_one_positive_val);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed while frozen");

    property p_cfg_reserved;
        @(posedge clk_i) disable iff (rst_i)
        cfg_reg[3:1] == 3'h0;
    endproperty
    a_cfg_reserved: assert property (p_cfg_reserved) else $error("cfg bits 3..1 set");

    property p_freeze_write;
        @(posedge clk_i) disable iff (rst_i)
        req && wb_we_i && wb_sel_i && wb_adr_i == 8'h59
            |=> freeze == $past(wb_dat_i[0]);
    endproperty
    a_freeze_write: assert property (p_freeze_write) else $error("freeze bit not written");

    property p_hi_read;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == 8'h5c |=> wb_ack_o && wb_dat_o == $past(bias_val[11:4]);
    endproperty
    a_hi_read: assert property (p_hi_read) else $error("high byte read wrong");

    property p_lo_read;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == 8'h5b
            |=> wb_dat_o == {$past(bat_val[3:0]), 4'h0};
    endproperty
    a_lo_read: assert property (p_lo_read) else $error("battery low read wrong");

    property p_tag_bias;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == 8'h5d |=> wb_dat_o[3:0] == 4'h1;
    endproperty
    a_tag_bias: assert property (p_tag_bias) else $error("bias tag wrong");

    property p_tag_input_one_positive;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == 8'h5f |=> wb_dat_o[3:0] == 4'h2;
    endproperty
    a_tag_input_one_positive: assert property (p_tag_input_one_positive) else $error("input tag wrong");

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        req && hit |=> s_ack_pulse;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");

    sequence s_bias_sample;
        conv_valid_i && conv_src_i == 2'h1 && !freeze;
    endsequence

    property p_refresh_bias;
        @(posedge clk_i) disable iff (rst_i)
        s_bias_sample |=> bias_val == $past(conv_data_i);
    endproperty
    a_refresh_bias: assert property (p_refresh_bias) else $error("bias not refreshed");

    sequence s_input_one_positive_sample;
        conv_valid_i && conv_src_i == 2'h2 && !freeze;
    endsequence

    property p_refresh_input_one_positive;
        @(posedge clk_i) disable iff (rst_i)
        s_input_one_positive_sample |=> input_one_positive_val == $past(conv_data_i);
    endproperty
    a_refresh_input_one_positive: assert property (p_refresh_input_one_positive) else $error("input not refreshed");

    property p_bat_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !(conv_valid_i && conv_src_i == 2'h0) |=> $stable(bat_val);
    endproperty
    a_bat_quiet: assert property (p_bat_quiet) else $error("bat changed idle");

    property p_bias_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !(conv_valid_i && conv_src_i == 2'h1) |=> $stable(bias_val);
    endproperty
    a_bias_quiet: assert property (p_bias_quiet) else $error("bias changed idle");

    property p_input_one_positive_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !(conv_valid_i && conv_src_i == 2'h2) |=> $stable(input_one_positive_val);
    endproperty
    a_input_one_positive_quiet: assert property (p_input_one_positive_quiet) else $error("input changed idle");

    property p_hi_read_bat;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == 8'h5a
            |=> wb_ack_o && wb_dat_o == $past(bat_val[11:4]);
    endproperty
    a_hi_read_bat: assert property (p_hi_read_bat) else $error("bat high wrong");

    property p_hi_read_input_one_positive;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == 8'h5e
            |=> wb_ack_o && wb_dat_o == $past(input_one_positive_val[11:4]);
    endproperty
    a_hi_read_input_one_positive: assert property (p_hi_read_input_one_positive) else $error("input high wrong");

    property p_lo_read_bias;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == 8'h5d
            |=> wb_dat_o == {$past(bias_val[3:0]), 4'h1};
    endproperty
    a_lo_read_bias: assert property (p_lo_read_bias) else $error("bias low wrong");

    property p_lo_read_input_one_positive;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == 8'h5f
            |=> wb_dat_o == {$past(input_one_positive_val[3:0]), 4'h2};
    endproperty
    a_lo_read_input_one_positive: assert property (p_lo_read_input_one_positive) else $error("input low wrong");

    property p_cfg_read;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == 8'h59
            |=> wb_dat_o[0] == $past(freeze) && wb_dat_o[3:1] == 3'h0;
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("cfg read wrong");

    property p_sel_low_write;
        @(posedge clk_i) disable iff (rst_i)
        req && wb_we_i && !wb_sel_i && wb_adr_i == 8'h59 |=> $stable(cfg_reg);
    endproperty
    a_sel_low_write: assert property (p_sel_low_write) else $error("write without sel");

    property p_reset_state;
        @(posedge clk_i)
        rst_i |=> !wb_ack_o && !wb_err_o && wb_dat_o == 8'h00 && cfg_reg == 8'h00
            && bat_val == 12'h000 && bias_val == 12'h000 && input_one_positive_val == 12'h000;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");

    ////////////////////////////////////////////////////////////////////////
    // Bus answer checks
    sequence s_err_pulse;
        (wb_err_o && !wb_ack_o) ##1 !wb_err_o;
    endsequence

    property p_err_once;
        @(posedge clk_i) disable iff (rst_i)
        req && !hit |=> s_err_pulse;
    endproperty
    a_err_once: assert property (p_err_once) else $error("err not a single pulse");

    property p_ack_answers;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> $past(req && hit);
    endproperty
    a_ack_answers: assert property (p_ack_answers) else $error("ack without request");

    property p_dat_hold;
        @(posedge clk_i) disable iff (rst_i)
        !(req && !wb_we_i) |=> $stable(wb_dat_o);
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data changed");

    property p_no_both;
        @(posedge clk_i) disable iff (rst_i)
        !(wb_ack_o && wb_err_o);
    endproperty
    a_no_both: assert property (p_no_both) else $error("ack and err together");
endmodule : dmr_readback

// ### tb_top.sv
// Self-checking bench of the diagnostic readback register bank
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [7:0] wb_dat_i = 8'h00;
    logic wb_sel_i = 1'b0;
    logic [7:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    logic conv_valid_i = 1'b0;
    logic [1:0] conv_src_i = 2'h0;
    dmr_pkg::dmr_result_t conv_data_i = 12'h000;
    logic freeze_monitor_update_o;
    int n_errors = 0;
    int tests_run = 0;
    integer seed = 32'h271e;
    dmr_pkg::dmr_result_t res [3] = '{default: 12'h000};
    logic frz = 1'b0;
    logic [7:0] rd;
    logic er;
    logic sel_b = 1'b1;

    always #20 clk_i = ~clk_i;

    dmr_readback u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .conv_valid_i(conv_valid_i), .conv_src_i(conv_src_i), .conv_data_i(conv_data_i),
        .freeze_monitor_update_o(freeze_monitor_update_o));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reset_reads;
        for (int a = 8'h59; a <= 8'h5f; a++)
        begin
            wb(1'b0, 8'(a), 8'h00);
            check("reset read", 12'(exp_rd(8'(a))), 12'(rd));
        end
    endtask : reset_reads

    // Classic cycle; also ends any converter pulse left high by samp
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int n;
        n = 0;
        conv_valid_i <= 1'b0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel_b;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
        begin
            n_errors++;
            report_and_stop();
        end
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // Leaves valid high so that calls may run back to back
    task automatic samp(input logic [1:0] s, input dmr_pkg::dmr_result_t d);
        conv_valid_i <= 1'b1;
        conv_src_i <= s;
        conv_data_i <= d;
        @(posedge clk_i);
        if (!frz && s != 2'h3)
            res[s] = d;
    endtask : samp

    function automatic logic [7:0] exp_rd(input logic [7:0] adr);
        logic [1:0] i;
        i = 2'((adr - 8'h5a) >> 1);
        if (adr == 8'h59)
            exp_rd = {7'h00, frz};
        else if (adr[0] == 1'b0)
            exp_rd = res[i][11:4];
        else
            exp_rd = {res[i][3:0], 2'h0, i};
    endfunction : exp_rd

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] a8;
        logic [7:0] hi;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_reads();
        for (int a = 0; a < 2; a++)
        begin
            wb(1'b0, a ? 8'h60 : 8'h58, 8'h00);
            check("unmapped err", 12'h001, {11'h000, er});
        end
        for (int k = 0; k < 80; k++)
        begin
            if (k % 8 == 0)
            begin
                // Reserved bits written as zero only
                wb(1'b1, 8'h59, {7'h00, ~frz});
                frz = ~frz;
                check("freeze out", {11'h000, frz}, {11'h000, freeze_monitor_update_o});
            end
            repeat (1 + k % 3) samp(2'($random(seed)), 12'($random(seed)));
            a8 = 8'h59 + 8'(($random(seed) & 7) % 7);
            wb(1'b0, a8, 8'h00);
            check("random read", 12'(exp_rd(a8)), 12'(rd));
            check("mapped err", 12'h000, {11'h000, er});
        end
        // Pair read under freeze with a fresh sample in between
        wb(1'b1, 8'h59, 8'h00);
        frz = 1'b0;
        samp(2'h2, 12'h9c5);
        wb(1'b1, 8'h59, 8'h01);
        frz = 1'b1;
        wb(1'b0, 8'h5e, 8'h00);
        hi = rd;
        samp(2'h2, 12'h3a7);
        wb(1'b0, 8'h5f, 8'h00);
        check("pair value", 12'h9c5, {hi, rd[7:4]});
        wb(1'b1, 8'h5e, 8'hff);
        wb(1'b0, 8'h5e, 8'h00);
        check("read-only high", 12'h09c, 12'(rd));
        wb(1'b1, 8'h59, 8'h00);
        frz = 1'b0;
        samp(2'h2, 12'h3a7);
        wb(1'b0, 8'h5f, 8'h00);
        check("resumed low", 12'h072, 12'(rd));
        // Byte select low: the write must leave the freeze bit alone
        sel_b = 1'b0;
        wb(1'b1, 8'h59, 8'h01);
        sel_b = 1'b1;
        check("sel low write", {11'h000, frz}, {11'h000, freeze_monitor_update_o});
        // Reset in mid-run with freeze set and results loaded
        wb(1'b1, 8'h59, 8'h01);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        frz = 1'b0;
        res = '{default: 12'h000};
        reset_reads();
        report_and_stop();
    end
endmodule : tb_top
